// ==== iro_router.sv ====
// Interrupt routing to two pins and user offset trim of the results
`timescale 1ns/1ns
`default_nettype none
//
// Behaviour
// - Routing register bits 7..0 map data ready, FIFO, windows, thresholds, changes.
// - Routing bit 0 sends a source to pin B, bit 1 to pin A.
// - Routing register resets to zero, so every source goes to pin B.
// - Each pin asserts on the OR of all enabled sources routed to it.
// - User offset registers hold two's-complement trims of temperature, pressure and altitude.
// - Pressure offset is 8-bit signed, 4 Pa per step, range +-512 Pa.
// - Temperature offset is 8-bit signed, 0.0625 degC per step, range +-8 degC.
// - Altitude offset is 8-bit signed whole meters, +-128 m, added to altitude.
// - All three offset registers reset to zero, so no trim applies.
// - Only sources with their enable bit set reach any pin.
// - Per-pin polarity bit, 0 active low by default, 1 active high.
// - Per-pin drive-type bit, 0 push-pull by default, 1 open drain.
module iro_router
  import iro_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // Register port from the serial interface front end
  input wire iro_pkg::iro_reg_req_t regReq,
  output logic [7:0] regRdata,
  output logic regAck,
  // Event levels from the detectors, same clock domain
  input wire logic [7:0] eventSrc,
  // Compensated results from the measurement path
  input wire iro_pkg::iro_result_t rawResult,
  input wire logic rawValid,
  // Trimmed results toward the output registers
  output iro_pkg::iro_result_t trimResult,
  output logic trimValid,
  // Interrupt pins, enable low while driving
  output logic irqPinAOut,
  output logic irqPinAOe_n,
  output logic irqPinBOut,
  output logic irqPinBOe_n
);

  // Software registers
  logic [7:0] irqRoutingReg;
  logic [7:0] irqEnableReg;
  logic [7:0] pinCfgReg;
  logic [7:0] offPress;
  logic [7:0] offTemp;
  logic [7:0] offAlt;

  // Address decode
  wire logic selPinCfg;
  wire logic selEnable;
  wire logic selRouting;
  wire logic selOffPress;
  wire logic selOffTemp;
  wire logic selOffAlt;

  assign selPinCfg = (regReq.addr == IRO_ADDR_PIN_CFG);
  assign selEnable = (regReq.addr == IRO_ADDR_ENABLE);
  assign selRouting = (regReq.addr == IRO_ADDR_ROUTING);
  assign selOffPress = (regReq.addr == IRO_ADDR_OFF_PRESS);
  assign selOffTemp = (regReq.addr == IRO_ADDR_OFF_TEMP);
  assign selOffAlt = (regReq.addr == IRO_ADDR_OFF_ALT);

  // Read selection; unmapped addresses read as zero
  wire logic [7:0] next_regRdata;

  assign next_regRdata =
    selPinCfg ? pinCfgReg :
    selEnable ? irqEnableReg :
    selRouting ? irqRoutingReg :
    selOffPress ? offPress :
    selOffTemp ? offTemp :
    selOffAlt ? offAlt :
    IRO_READ_UNMAPPED;

  // Configuration registers
  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      irqRoutingReg <= IRO_RST_ROUTING;
      irqEnableReg <= IRO_RST_ENABLE;
      pinCfgReg <= IRO_RST_PIN_CFG;
    end
    else if (regReq.write)
    begin
      if (selRouting)
        irqRoutingReg <= regReq.wdata;
      if (selEnable)
        irqEnableReg <= regReq.wdata;
      if (selPinCfg)
        pinCfgReg <= regReq.wdata;
    end
  end

  // Offset trim registers
  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      offPress <= IRO_RST_OFFSET;
      offTemp <= IRO_RST_OFFSET;
      offAlt <= IRO_RST_OFFSET;
    end
    else if (regReq.write)
    begin
      if (selOffPress)
        offPress <= regReq.wdata;
      if (selOffTemp)
        offTemp <= regReq.wdata;
      if (selOffAlt)
        offAlt <= regReq.wdata;
    end
  end

  // Register answer: one cycle after the request, for reads and writes
  // Unmapped accesses are answered too, so the serial front end never stalls
  // Read data is held between reads, so the front end may fetch it late
  // A write does not disturb the held read data
  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      regRdata <= 8'h00;
      regAck <= 1'b0;
    end
    else
    begin
      regAck <= regReq.read | regReq.write;
      if (regReq.read)
        regRdata <= next_regRdata;
    end
  end

  // Interrupt routing
  wire logic [7:0] enabledSrc;
  wire logic [7:0] toPinA;
  wire logic [7:0] toPinB;
  wire logic pinAActive;
  wire logic pinBActive;
  wire iro_pin_cfg_t pinACfg;
  wire iro_pin_cfg_t pinBCfg;

  // A disabled source is dropped before routing, so it reaches neither pin
  assign enabledSrc = eventSrc & irqEnableReg;
  assign toPinA = enabledSrc & irqRoutingReg;
  assign toPinB = enabledSrc & ~irqRoutingReg;
  // Wired OR per pin over the enabled sources routed to it
  assign pinAActive = |toPinA;
  assign pinBActive = |toPinB;

  assign pinACfg.polarity = pinCfgReg[IRO_CFG_PIN_A_POLARITY];
  assign pinACfg.driveType = pinCfgReg[IRO_CFG_PIN_A_DRIVE_TYPE];
  assign pinBCfg.polarity = pinCfgReg[IRO_CFG_PIN_B_POLARITY];
  assign pinBCfg.driveType = pinCfgReg[IRO_CFG_PIN_B_DRIVE_TYPE];

  iro_pin_drive pinADrive (
    .clk(clk),
    .sys_rst(sys_rst),
    .irqActive(pinAActive),
    .cfg(pinACfg),
    .pinOut(irqPinAOut),
    .pinOe_n(irqPinAOe_n)
  );

  iro_pin_drive pinBDrive (
    .clk(clk),
    .sys_rst(sys_rst),
    .irqActive(pinBActive),
    .cfg(pinBCfg),
    .pinOut(irqPinBOut),
    .pinOe_n(irqPinBOe_n)
  );

  // Offset scaling: sign-extend to the result width, then shift into its units
  wire logic [IRO_PRESS_W-1:0] pressOffExt;
  wire logic [IRO_TEMP_W-1:0] tempOffExt;
  wire logic [IRO_ALT_W-1:0] altOffExt;
  wire logic [IRO_PRESS_W-1:0] pressOffScaled;
  wire logic [IRO_TEMP_W-1:0] tempOffScaled;
  wire logic [IRO_ALT_W-1:0] altOffScaled;

  assign pressOffExt = {{(IRO_PRESS_W-8){offPress[7]}}, offPress};
  assign tempOffExt = {{(IRO_TEMP_W-8){offTemp[7]}}, offTemp};
  assign altOffExt = {{(IRO_ALT_W-8){offAlt[7]}}, offAlt};
  // 4 Pa per step against a quarter-pascal result
  assign pressOffScaled = pressOffExt << IRO_PRESS_OFF_SHIFT;
  // 0.0625 degC per step matches the temperature result step
  assign tempOffScaled = tempOffExt << IRO_TEMP_OFF_SHIFT;
  // Whole meters against a result with four fraction bits
  assign altOffScaled = altOffExt << IRO_ALT_OFF_SHIFT;

  // Trimmed sums; they wrap at the result width, no saturation is applied
  wire iro_result_t next_trimResult;

  assign next_trimResult.press = rawResult.press + pressOffScaled;
  assign next_trimResult.temp = rawResult.temp + tempOffScaled;
  assign next_trimResult.alt = rawResult.alt + altOffScaled;

  // Trimmed results register: the output registers see only trimmed values
  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      trimResult <= '0;
      trimValid <= 1'b0;
    end
    else
    begin
      trimValid <= rawValid;
      if (rawValid)
        trimResult <= next_trimResult;
    end
  end

endmodule
`default_nettype wire

// ==== iro_pkg.sv ====
// Package for the interrupt router and user offset trim block
package iro_pkg;

  // Register indices on the serial register port
  localparam logic [7:0] IRO_ADDR_PIN_CFG = 8'h28;
  localparam logic [7:0] IRO_ADDR_ENABLE = 8'h29;
  localparam logic [7:0] IRO_ADDR_ROUTING = 8'h2a;
  localparam logic [7:0] IRO_ADDR_OFF_PRESS = 8'h2b;
  localparam logic [7:0] IRO_ADDR_OFF_TEMP = 8'h2c;
  localparam logic [7:0] IRO_ADDR_OFF_ALT = 8'h2d;

  // Values after reset
  localparam logic [7:0] IRO_RST_PIN_CFG = 8'h00;
  localparam logic [7:0] IRO_RST_ENABLE = 8'h00;
  localparam logic [7:0] IRO_RST_ROUTING = 8'h00;
  localparam logic [7:0] IRO_RST_OFFSET = 8'h00;
  localparam logic [7:0] IRO_READ_UNMAPPED = 8'h00;

  // Event source bit positions, shared by enable and routing registers
  localparam int IRO_SRC_DATA_READY = 7;
  localparam int IRO_SRC_FIFO = 6;
  localparam int IRO_SRC_PRESS_WINDOW = 5;
  localparam int IRO_SRC_TEMP_WINDOW = 4;
  localparam int IRO_SRC_PRESS_THRESHOLD = 3;
  localparam int IRO_SRC_TEMP_THRESHOLD = 2;
  localparam int IRO_SRC_PRESS_CHANGE = 1;
  localparam int IRO_SRC_TEMP_CHANGE = 0;
  localparam int IRO_NUM_SRC = 8;

  // Pin configuration register field positions
  localparam int IRO_CFG_PIN_A_POLARITY = 5;
  localparam int IRO_CFG_PIN_A_DRIVE_TYPE = 4;
  localparam int IRO_CFG_PIN_B_POLARITY = 1;
  localparam int IRO_CFG_PIN_B_DRIVE_TYPE = 0;

  // Result widths and fixed-point layout
  localparam int IRO_PRESS_W = 20;
  localparam int IRO_TEMP_W = 12;
  localparam int IRO_ALT_W = 20;
  // Pressure result in quarter pascals, offset step 4 Pa = 16 quarters
  localparam int IRO_PRESS_OFF_SHIFT = 4;
  // Temperature result in 1/16 degC, offset step equals one result step
  localparam int IRO_TEMP_OFF_SHIFT = 0;
  // Altitude result in 1/16 m, offset step is one whole meter
  localparam int IRO_ALT_OFF_SHIFT = 4;

  // One register access request from the serial front end
  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic write;
    logic read;
  } iro_reg_req_t;

  // Per-pin electrical configuration
  typedef struct packed {
    logic polarity;
    logic driveType;
  } iro_pin_cfg_t;

  // Compensated results before or after trimming
  typedef struct packed {
    logic [IRO_PRESS_W-1:0] press;
    logic [IRO_TEMP_W-1:0] temp;
    logic [IRO_ALT_W-1:0] alt;
  } iro_result_t;

endpackage

// ==== iro_pin_drive.sv ====
// Output stage for one interrupt pin: polarity and push-pull or open drain
`timescale 1ns/1ns
`default_nettype none
module iro_pin_drive
  import iro_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // Request and configuration
  input wire logic irqActive,
  input wire iro_pkg::iro_pin_cfg_t cfg,
  // Pin, enable low while driving
  output logic pinOut,
  output logic pinOe_n
);

  wire logic level;
  wire logic release_n;

  // Polarity 0 signals an interrupt with a low level
  assign level = cfg.polarity ? irqActive : ~irqActive;
  // Open drain only ever pulls low; a high level is left to the pull-up
  assign release_n = ~(cfg.driveType & level);

  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      pinOut <= 1'b1;
      pinOe_n <= 1'b0;
    end
    else
    begin
      pinOut <= level;
      pinOe_n <= ~release_n;
    end
  end

endmodule
`default_nettype wire

// ==== iro_router_props.sv ====
// Port-level assertions for the interrupt router
`timescale 1ns/1ns
`default_nettype none
module iro_router_props
  import iro_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // Register port
  input wire iro_pkg::iro_reg_req_t regReq,
  input wire logic [7:0] regRdata,
  input wire logic regAck,
  // Events and results
  input wire logic [7:0] eventSrc,
  input wire logic rawValid,
  input wire iro_pkg::iro_result_t trimResult,
  input wire logic trimValid,
  // Pins
  input wire logic irqPinAOut,
  input wire logic irqPinAOe_n,
  input wire logic irqPinBOut,
  input wire logic irqPinBOe_n
);
  default clocking @(posedge clk); endclocking
  default disable iff (sys_rst);
  wire logic req = regReq.read | regReq.write;
  wire logic [3:0] pins = {irqPinAOut, irqPinAOe_n, irqPinBOut, irqPinBOe_n};
  wire logic unmapped = regReq.addr < IRO_ADDR_PIN_CFG || regReq.addr > IRO_ADDR_OFF_ALT;
  a_ack_follows_req: assert property (req |=> regAck) else $error("ack missing");
  a_ack_has_cause: assert property (regAck |-> $past(req)) else $error("stray ack");
  a_unmapped_reads_zero: assert property (regReq.read && unmapped |=> regRdata == 8'h00)
    else $error("unmapped read not zero");
  a_rdata_holds: assert property (!regReq.read |=> $stable(regRdata)) else $error("rdata moved");
  // Pins may only move after an active event or a register write
  a_pins_quiet: assert property ((!regReq.write && eventSrc == 8'h00) [*2] |=> $stable(pins))
    else $error("pin moved without cause");
  a_pins_after_reset: assert property ($fell(sys_rst) |-> pins == 4'b1010)
    else $error("pins not idle after reset");
  a_open_drain_release: assert property ((!irqPinAOe_n || irqPinAOut) && (!irqPinBOe_n || irqPinBOut))
    else $error("released pin not high");
  a_trim_follows_raw: assert property (rawValid |=> trimValid) else $error("trim late");
  a_trim_has_cause: assert property (trimValid |-> $past(rawValid)) else $error("stray trim");
  a_trim_holds: assert property (!rawValid |=> $stable(trimResult)) else $error("trim moved");
  c_write: cover property (regReq.write && !unmapped);
  c_trim: cover property (trimValid);
  c_pin_released: cover property (irqPinAOe_n);
endmodule
bind iro_router iro_router_props i_props (.clk(clk), .sys_rst(sys_rst), .regReq(regReq),
  .regRdata(regRdata), .regAck(regAck), .eventSrc(eventSrc), .rawValid(rawValid),
  .trimResult(trimResult), .trimValid(trimValid), .irqPinAOut(irqPinAOut),
  .irqPinAOe_n(irqPinAOe_n), .irqPinBOut(irqPinBOut), .irqPinBOe_n(irqPinBOe_n));
`default_nettype wire

// ==== iro_host_model.sv ====
// Host side of the interrupt lines, with pull-ups
`timescale 1ns/1ns
`default_nettype none
module iro_host_model
(
  // Pin drivers from the device
  input wire logic aOut,
  input wire logic aOe_n,
  input wire logic bOut,
  input wire logic bOe_n,
  // Line levels seen by the host
  output logic lineA,
  output logic lineB
);
  // A released line floats up, so the host never sees a stale low
  assign lineA = aOe_n ? 1'b1 : aOut;
  assign lineB = bOe_n ? 1'b1 : bOut;
endmodule
`default_nettype wire

// ==== tb_top.sv ====
// Self-checking bench for the interrupt router and offset trim
`timescale 1ns/1ns
`default_nettype none
module tb_top;
  import iro_pkg::*;
  logic clk = 1'b0;
  logic sys_rst = 1'b1;
  iro_reg_req_t regReq = '0;
  logic [7:0] eventSrc = 8'h00;
  iro_result_t rawResult = '0;
  logic rawValid = 1'b0;
  logic [7:0] regRdata;
  logic regAck, trimValid, aOut, aOe_n, bOut, bOe_n, lineA, lineB;
  iro_result_t trimResult;
  int fail_count = 0;
  int n_tests = 0;
  int cycles = 0;
  always #50 clk = ~clk;
  iro_router i_dut (.clk(clk), .sys_rst(sys_rst), .regReq(regReq), .regRdata(regRdata),
    .regAck(regAck), .eventSrc(eventSrc), .rawResult(rawResult), .rawValid(rawValid),
    .trimResult(trimResult), .trimValid(trimValid), .irqPinAOut(aOut),
    .irqPinAOe_n(aOe_n), .irqPinBOut(bOut), .irqPinBOe_n(bOe_n));
  iro_host_model i_host (.aOut(aOut), .aOe_n(aOe_n), .bOut(bOut), .bOe_n(bOe_n),
    .lineA(lineA), .lineB(lineB));
  task automatic chk(input logic [52:0] got, input logic [52:0] exp);
    n_tests++;
    if (got !== exp)
    begin
      fail_count++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic conclude();
    $display("Counts: %0d compares, %0d mismatches", n_tests, fail_count);
    if (fail_count == 0 && n_tests > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  // Strobe drops at the taking edge; the ack pulse is looked at just after it
  task automatic acc(input logic [7:0] a, input logic [7:0] d, input logic wr);
    @(posedge clk);
    regReq <= '{addr: a, wdata: d, write: wr, read: !wr};
    @(posedge clk);
    regReq.write <= 1'b0;
    regReq.read <= 1'b0;
    #1;
    chk(regAck, 1'b1);
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    acc(a, 8'h00, 1'b0);
    chk(regRdata, exp);
  endtask
  // Event levels, then line A, line B, enable A, enable B two edges on
  task automatic pn(input logic [7:0] ev, input logic [3:0] exp);
    @(posedge clk);
    eventSrc <= ev;
    repeat (2) @(posedge clk);
    #1;
    chk({lineA, lineB, aOe_n, bOe_n}, exp);
  endtask
  task automatic trim(input logic [51:0] raw, input logic [51:0] exp);
    @(posedge clk);
    rawValid <= 1'b1;
    rawResult <= raw;
    @(posedge clk);
    rawValid <= 1'b0;
    #1;
    chk({trimValid, trimResult}, {1'b1, exp});
  endtask
  always @(posedge clk)
  begin
    cycles++;
    if (cycles == 3000)
    begin
      fail_count++;
      conclude();
    end
  end
  initial
  begin
    repeat (12) @(posedge clk);
    sys_rst <= 1'b0;
    for (int i = 0; i < 7; i++)
      rd(8'h28 + i[7:0], 8'h00);
    pn(8'hff, 4'b1100);
    trim({20'd100, 12'h100, 20'h01000}, {20'd100, 12'h100, 20'h01000});
    $display("reset test done");
    acc(IRO_ADDR_ENABLE, 8'hff, 1'b1);
    // Routing still at its reset value: every enabled source lands on line B
    pn(8'h81, 4'b1000);
    for (int i = 0; i < IRO_NUM_SRC; i++)
    begin
      acc(IRO_ADDR_ROUTING, 8'h01 << i, 1'b1);
      rd(IRO_ADDR_ROUTING, 8'h01 << i);
      pn(8'h01 << i, 4'b0100);
      pn(~(8'h01 << i), 4'b1000);
      // Host answers an active line by reading back the configuration
      rd(IRO_ADDR_ENABLE, 8'hff);
    end
    $display("routing test done");
    acc(IRO_ADDR_ROUTING, 8'hf0, 1'b1);
    acc(IRO_ADDR_ENABLE, 8'h0f, 1'b1);
    pn(8'hf0, 4'b1100);
    pn(8'h0f, 4'b1000);
    acc(IRO_ADDR_ENABLE, 8'hff, 1'b1);
    acc(IRO_ADDR_PIN_CFG, 8'h33, 1'b1);
    pn(8'h00, 4'b0000);
    pn(8'h80, 4'b1010);
    acc(IRO_ADDR_PIN_CFG, 8'h11, 1'b1);
    pn(8'h01, 4'b1010);
    acc(IRO_ADDR_PIN_CFG, 8'h20, 1'b1);
    pn(8'h80, 4'b1100);
    $display("pin test done");
    acc(IRO_ADDR_OFF_PRESS, 8'hff, 1'b1);
    acc(IRO_ADDR_OFF_TEMP, 8'h80, 1'b1);
    acc(IRO_ADDR_OFF_ALT, 8'h7f, 1'b1);
    rd(IRO_ADDR_OFF_TEMP, 8'h80);
    trim({20'd100, 12'h100, 20'h01000}, {20'd84, 12'h080, 20'h017f0});
    $display("offset test done");
    conclude();
  end
endmodule
`default_nettype wire
